// ===== core/pwm_unit_pkg.sv
// Purpose: constants shared by the timer pwm output unit
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: register byte address is four times the register index
`default_nettype none
package pwm_unit_pkg;
  // ***********************************************************
  // register indices and address layout
  // ***********************************************************
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_CONTROL = 10'h0A0;
  localparam logic [9:0] IDX_COUNT = 10'h0A1;
  localparam logic [9:0] IDX_RELOAD = 10'h0A2;
  localparam logic [9:0] IDX_DUTY = 10'h0A3;
  localparam logic [9:0] IDX_STATUS = 10'h0A4;
  localparam logic [9:0] IDX_CHANNEL_SELECT = 10'h0AC;
  localparam logic [9:0] IDX_EXTENSION_SELECT = 10'h0DE;
  localparam int IDX_LSB = 2;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int CTL_OUT_EN = 0;
  localparam int CTL_ONE_PULSE = 1;
  localparam int CTL_RATE_LSB = 4;
  localparam int CTL_RATE_MSB = 6;
  localparam int CTL_TIMER_EN = 7;
  localparam int STS_FLAG = 0;
  localparam int STS_IRQ_EN = 1;
  localparam int STS_CLK_MODE = 2;
  localparam int CH_A = 0;
  localparam int CH_B = 1;

  // ***********************************************************
  // reset values and constants
  // ***********************************************************
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] CH_ZERO = 2'h0;
  localparam logic [6:0] PRESCALE_FULL = 7'h7F;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_P1 = 2'h1;
  localparam logic [1:0] EXT_P13 = 2'h2;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***********************************************************
  // timing: low oscillator derived from the bus clock
  // ***********************************************************
  localparam int CLK_HZ = 125000000;
  localparam int LOW_OSC_HZ = 32000;
  localparam int LOW_OSC_DIV = CLK_HZ / LOW_OSC_HZ;
  localparam int LOW_DIV_W = 12;
endpackage
`default_nettype wire

// ===== core/timer_pwm_output_unit.sv
// Purpose: 8-bit auto-reload timer driving a two-pin pwm output stage
// Assumes: aclk is the high oscillator; low oscillator is an enable pulse
// Notes: registers reached over AXI4-Lite
//
// Behaviour
// - pwm on pin needs timer, output enable, select
// - disabling returns pins to gpio immediately
// - each period starts high, ends low
// - counter loads reload on enable and overflow
// - counter equals duty ends the high phase
// - overflow ends period, output goes high
// - period and duty changes apply next period
// - select bit0 pin a, bit1 pin b
// - no select bits keeps both pins gpio
// - duty not above reload keeps output low
// - overflow sets flag, irq if enabled
// - one pulse clears output enable after period
// - one pulse pin returns after low portion
// - extension ignored in one pulse mode
// - extension field picks compensated phases
// - four timer periods form one extended cycle
// - extension change waits for four-phase end
// - timer re-enable resets phase counter
// - pin switches to pwm after first tick, one pulse at enable edge or overflow
// - both pins carry identical waveform
// - clock mode and prescaler divide source clock
// - hardware sets flag, software clears it
//
// Our own choice: the AXI4-Lite register port.
`default_nettype none
module timer_pwm_output_unit
  import pwm_unit_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic irq_request
);

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic phase_compensated(input logic [1:0] ext, input logic [1:0] phase);
    case (ext)
      EXT_NONE: phase_compensated = 1'b0;
      EXT_P1: phase_compensated = (phase == 2'h1);
      EXT_P13: phase_compensated = (phase == 2'h1) || (phase == PHASE_LAST);
      default: phase_compensated = (phase != 2'h0);
    endcase
  endfunction

  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[IDX_LSB +: 10];
  endfunction

  // true for every index that holds a register
  function automatic logic is_mapped(input logic [9:0] idx);
    case (idx)
      IDX_CONTROL, IDX_COUNT, IDX_RELOAD, IDX_DUTY, IDX_STATUS, IDX_CHANNEL_SELECT,
      IDX_EXTENSION_SELECT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // ***********************************************************
  // state
  // ***********************************************************
  logic timer_en_reg, out_en_reg, one_pulse_reg, clk_mode_reg, irq_en_reg, flag_reg;
  logic [2:0] rate_reg;
  logic [7:0] count_reg, reload_reg, duty_reg, reload_act_reg, duty_act_reg;
  logic [1:0] chan_reg, ext_reg, ext_act_reg, phase_reg;
  logic timer_en_q_reg, pwm_level_reg, live_reg;
  logic [6:0] pre_reg;
  logic [LOW_DIV_W-1:0] low_div_reg;
  logic aw_full_reg, w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // ***********************************************************
  // AXI4-Lite write path
  // ***********************************************************
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire b_take = s_axi_bvalid && s_axi_bready;
  // a write lands once both halves are held and no response waits
  wire wr_do = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire aw_full_next = (aw_full_reg || aw_take) && !wr_do;
  wire w_full_next = (w_full_reg || w_take) && !wr_do;
  wire bvalid_next = wr_do || (s_axi_bvalid && !b_take);
  wire [9:0] wr_idx = reg_index(aw_addr_reg);
  wire wr_lane = wr_do && w_strb_reg[0];
  wire [7:0] wr_byte = w_data_reg[7:0];
  wire wr_ctl = wr_lane && (wr_idx == IDX_CONTROL);
  wire wr_cnt = wr_lane && (wr_idx == IDX_COUNT);
  wire wr_rld = wr_lane && (wr_idx == IDX_RELOAD);
  wire wr_dty = wr_lane && (wr_idx == IDX_DUTY);
  wire wr_sts = wr_lane && (wr_idx == IDX_STATUS);
  wire wr_chn = wr_lane && (wr_idx == IDX_CHANNEL_SELECT);
  wire wr_ext = wr_lane && (wr_idx == IDX_EXTENSION_SELECT);
  wire wr_hit = is_mapped(wr_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      // no new address while a response is pending
      s_axi_awready <= !aw_full_next && !aw_take && !bvalid_next;
      s_axi_wready <= !w_full_next && !w_take;
      s_axi_bvalid <= bvalid_next;
      if (wr_do) begin
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ***********************************************************
  // AXI4-Lite read path
  // ***********************************************************
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_take = s_axi_rvalid && s_axi_rready;
  wire [9:0] rd_idx = reg_index(s_axi_araddr);
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = BYTE_ZERO;
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_CONTROL: rd_byte = {timer_en_reg, rate_reg, 2'b00, one_pulse_reg, out_en_reg};
      IDX_COUNT: rd_byte = count_reg;
      IDX_RELOAD: rd_byte = BYTE_ZERO;
      IDX_DUTY: rd_byte = duty_reg;
      IDX_STATUS: rd_byte = {5'b00000, clk_mode_reg, irq_en_reg, flag_reg};
      IDX_CHANNEL_SELECT: rd_byte = {6'b000000, chan_reg};
      IDX_EXTENSION_SELECT: rd_byte = {6'b000000, ext_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !(s_axi_rvalid && !r_take) && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (r_take) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // timer clock: source select and prescaler
  // ***********************************************************
  wire low_tick = (low_div_reg == LOW_DIV_W'(LOW_OSC_DIV - 1));
  wire src_tick = clk_mode_reg ? low_tick : 1'b1;
  wire [6:0] pre_mask = PRESCALE_FULL >> rate_reg;
  wire tick = timer_en_reg && src_tick && ((pre_reg & pre_mask) == pre_mask);

  // ***********************************************************
  // counter, reload and pwm phase logic
  // ***********************************************************
  wire en_rise = timer_en_reg && !timer_en_q_reg;
  // the enable edge reloads, so no overflow is counted there
  wire overflow = tick && !en_rise && (count_reg == COUNT_MAX);
  wire [7:0] count_inc = count_reg + 8'h01;
  wire phase_wrap = (phase_reg == PHASE_LAST);
  wire [1:0] ext_use = one_pulse_reg ? EXT_NONE : ext_act_reg;
  wire [1:0] phase_new = phase_reg + 2'h1;
  wire [1:0] ext_new = phase_wrap ? ext_reg : ext_act_reg;
  wire stretch = phase_compensated(ext_use, phase_reg) && (duty_act_reg != COUNT_MAX);
  wire [7:0] duty_end = stretch ? duty_act_reg + 8'h01 : duty_act_reg;
  wire pulse_done = overflow && one_pulse_reg && out_en_reg && live_reg;
  wire pwm_run = timer_en_reg && out_en_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_div_reg <= '0;
      pre_reg <= '0;
      timer_en_q_reg <= 1'b0;
    end else begin
      low_div_reg <= low_tick ? '0 : low_div_reg + LOW_DIV_W'(1);
      if (src_tick) begin
        pre_reg <= pre_reg + 7'h01;
      end
      timer_en_q_reg <= timer_en_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= BYTE_ZERO;
      reload_act_reg <= BYTE_ZERO;
      duty_act_reg <= BYTE_ZERO;
      ext_act_reg <= EXT_NONE;
      phase_reg <= 2'h0;
      pwm_level_reg <= 1'b0;
    end else if (en_rise) begin
      count_reg <= reload_reg;
      reload_act_reg <= reload_reg;
      duty_act_reg <= duty_reg;
      ext_act_reg <= ext_reg;
      phase_reg <= 2'h0;
      pwm_level_reg <= (duty_reg > reload_reg);
    end else if (wr_cnt) begin
      count_reg <= wr_byte;
    end else if (overflow) begin
      count_reg <= reload_reg;
      reload_act_reg <= reload_reg;
      duty_act_reg <= duty_reg;
      phase_reg <= phase_new;
      ext_act_reg <= ext_new;
      // the next period restarts high unless the duty is not above the reload
      pwm_level_reg <= (duty_reg > reload_reg);
    end else if (tick) begin
      count_reg <= count_inc;
      if (count_inc == duty_end) begin
        pwm_level_reg <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // software registers and flags
  // ***********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_en_reg <= 1'b0;
      out_en_reg <= 1'b0;
      one_pulse_reg <= 1'b0;
      rate_reg <= 3'h0;
      clk_mode_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      flag_reg <= 1'b0;
      reload_reg <= BYTE_ZERO;
      duty_reg <= BYTE_ZERO;
      chan_reg <= CH_ZERO;
      ext_reg <= EXT_NONE;
    end else begin
      if (wr_ctl) begin
        timer_en_reg <= wr_byte[CTL_TIMER_EN];
        rate_reg <= wr_byte[CTL_RATE_MSB:CTL_RATE_LSB];
        one_pulse_reg <= wr_byte[CTL_ONE_PULSE];
        out_en_reg <= wr_byte[CTL_OUT_EN];
      end else if (pulse_done) begin
        out_en_reg <= 1'b0;
      end
      if (overflow) begin
        flag_reg <= 1'b1;
      end else if (wr_sts && wr_byte[STS_FLAG]) begin
        flag_reg <= 1'b0;
      end
      if (wr_sts) begin
        irq_en_reg <= wr_byte[STS_IRQ_EN];
        clk_mode_reg <= wr_byte[STS_CLK_MODE];
      end
      if (wr_rld) begin
        reload_reg <= wr_byte;
      end
      if (wr_dty) begin
        duty_reg <= wr_byte;
      end
      if (wr_chn) begin
        chan_reg <= wr_byte[1:0];
      end
      if (wr_ext) begin
        ext_reg <= wr_byte[1:0];
      end
    end
  end

  // ***********************************************************
  // pin multiplexer
  // ***********************************************************
  // continuous pwm goes live at the first tick after arming
  // a single pulse waits for a period start so it is never cut short
  wire start_ok = one_pulse_reg ? (en_rise || overflow) : tick;
  wire live_next = pwm_run && (live_reg || start_ok) && !pulse_done;
  // a pin follows only once live has stood a cycle, so a stale level never shows
  wire [1:0] route = (live_reg && live_next) ? chan_reg : CH_ZERO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_reg <= 1'b0;
      pin_out <= CH_ZERO;
      pin_oe <= CH_ZERO;
      irq_request <= 1'b0;
    end else begin
      live_reg <= live_next;
      pin_out[CH_A] <= route[CH_A] ? pwm_level_reg : gpio_out[CH_A];
      pin_out[CH_B] <= route[CH_B] ? pwm_level_reg : gpio_out[CH_B];
      pin_oe[CH_A] <= route[CH_A] | gpio_oe[CH_A];
      pin_oe[CH_B] <= route[CH_B] | gpio_oe[CH_B];
      irq_request <= (flag_reg || overflow) && irq_en_reg;
    end
  end

endmodule
`default_nettype wire

// ===== sim/pwm_unit_props.sv
// Purpose: port checks for the timer pwm output unit
// Assumes: the master offers write address and data together
// Notes: bound to the top module
`default_nettype none
module pwm_unit_props
  import pwm_unit_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic irq_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire [9:0] wr_idx = s_axi_awaddr[ADDR_W-1:IDX_LSB];
  wire ctl_off = wr_take && wr_idx == IDX_CONTROL && !(s_axi_wdata[CTL_OUT_EN] && s_axi_wdata[CTL_TIMER_EN]);
  wire sel_none = wr_take && wr_idx == IDX_CHANNEL_SELECT && s_axi_wdata[1:0] == CH_ZERO;
  wire irq_off = wr_take && wr_idx == IDX_STATUS && !s_axi_wdata[STS_IRQ_EN];
  wire gpio_back = pin_out == gpio_out && pin_oe == gpio_oe;
  AST_B_AFTER: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address taken while busy");
  AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_UNMAPPED: assert property (wr_take && s_axi_awaddr == 12'h000 |-> ##2 s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_OFF_GPIO: assert property (ctl_off |-> ##[2:5] gpio_back) else $error("pins not back to gpio");
  AST_NO_SELECT: assert property (sel_none |-> ##[3:4] gpio_back [*3]) else $error("unselected pin driven");
  AST_IRQ_OFF: assert property (irq_off |-> ##[2:3] !irq_request) else $error("irq not masked");
  AST_SAME_WAVE: assert property (pin_oe == 2'h3 && pin_out[0] != pin_out[1]
    |-> pin_out[0] == gpio_out[0] || pin_out[1] == gpio_out[1]) else $error("pins differ");
endmodule
bind timer_pwm_output_unit pwm_unit_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .gpio_out, .gpio_oe,
  .pin_out, .pin_oe, .irq_request);
`default_nettype wire

// ===== sim/pin_load.sv
// Purpose: external load on the two shared pins
// Assumes: each pin line has a pull-down
// Notes: a released pin reads low
`default_nettype none
module pin_load (
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_level = pin_out & pin_oe;
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Purpose: self-checking bench for the timer pwm output unit
// Assumes: prescale /1 on the bus clock except in the prescale test
// Notes: widths measured on pin a at the load
`default_nettype none
module tb;
  import pwm_unit_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_request;
  logic [1:0] s_axi_bresp, s_axi_rresp, pin_out, pin_oe, pin_level;
  logic [1:0] gpio_out = 2'h2, gpio_oe = 2'h3;
  logic [3:0] comp [4] = '{4'h0, 4'h1, 4'h5, 4'h7};
  int n_errors = 0, checks = 0;
  always #4 aclk = ~aclk;
  timer_pwm_output_unit u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_out,
    .gpio_oe, .pin_out, .pin_oe, .irq_request);
  pin_load u_load (.pin_out, .pin_oe, .pin_level);
  // ****************************************
  // bus and measurement tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    bit ap = 1'b1;
    bit wp = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (ap || wp) begin
      @(posedge aclk);
      ap = ap && !s_axi_awready;
      wp = wp && !s_axi_wready;
      s_axi_awvalid <= ap;
      s_axi_wvalid <= wp;
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er, "bresp");
  endtask
  task automatic rd(input logic [9:0] idx, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    while (s_axi_arready !== 1'h1) @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask
  task automatic lvl_wait(input logic v);
    for (int n = 0; n < 300 && pin_level[0] !== v; n++) @(negedge aclk);
  endtask
  task automatic meas(output int w, output int p);
    w = 0;
    p = 0;
    for (; p < 300 && pin_level[0] === 1'h1; p++) @(negedge aclk);
    w = p;
    for (; p < 300 && pin_level[0] === 1'h0; p++) @(negedge aclk);
  endtask
  // pwm stops before setup so each enable restarts the four phases
  task automatic start(input logic [7:0] rl, du, ch, ex, lo);
    wr(IDX_CONTROL, 8'h70);
    wr(IDX_COUNT, rl);
    wr(IDX_RELOAD, rl);
    wr(IDX_DUTY, du);
    wr(IDX_CHANNEL_SELECT, ch);
    wr(IDX_EXTENSION_SELECT, ex);
    wr(IDX_CONTROL, lo);
    wr(IDX_CONTROL, lo | 8'h80);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    rd(IDX_CHANNEL_SELECT, d);
    chk(d, 32'h0, "channel select reset");
    rd(IDX_EXTENSION_SELECT, d);
    chk(d, 32'h0, "extension reset");
    wr(10'h000, 8'h5A, RESP_SLVERR);
    wr(IDX_EXTENSION_SELECT, 8'h03);
    rd(IDX_EXTENSION_SELECT, d);
    chk(d, 32'h3, "extension readback");
    wr(IDX_RELOAD, 8'h12);
    rd(IDX_RELOAD, d);
    chk(d, 32'h0, "reload write only");
    $display("test regs done");
  endtask
  task automatic t_cont();
    int w, p, bad;
    start(8'hF0, 8'hF4, 8'h03, 8'h00, 8'h71);
    lvl_wait(1'h1);
    meas(w, p);
    meas(w, p);
    chk(w, 4, "high width");
    chk(p, 16, "period");
    wr(IDX_RELOAD, 8'hE0);
    wr(IDX_DUTY, 8'hE8);
    lvl_wait(1'h0);
    lvl_wait(1'h1);
    meas(w, p);
    chk({w[15:0], p[15:0]}, {16'd8, 16'd32}, "new period");
    wr(IDX_CONTROL, 8'h70);
    repeat (4) @(negedge aclk);
    chk({pin_oe, pin_out}, {gpio_oe, gpio_out}, "gpio restored");
    wr(IDX_CHANNEL_SELECT, 8'h00);
    wr(IDX_CONTROL, 8'hF1);
    bad = 0;
    repeat (40) begin
      @(negedge aclk);
      bad += int'(pin_out !== gpio_out);
    end
    chk(bad, 0, "no channel selected");
    $display("test continuous done");
  endtask
  task automatic t_rate();
    int w, p;
    start(8'hF0, 8'hF4, 8'h03, 8'h00, 8'h61);
    lvl_wait(1'h1);
    meas(w, p);
    meas(w, p);
    chk(w, 8, "high width at half rate");
    chk(p, 32, "period at half rate");
    $display("test prescale done");
  endtask
  task automatic t_low();
    logic [31:0] d;
    int bad = 0;
    @(posedge aclk);
    gpio_out <= 2'h3;
    start(8'hE0, 8'hE0, 8'h03, 8'h00, 8'h71);
    wr(IDX_STATUS, 8'h02);
    repeat (40) begin
      @(negedge aclk);
      bad += int'(pin_out[0] !== 1'h0);
    end
    chk(bad, 0, "output held low");
    chk(irq_request, 1'h1, "irq");
    rd(IDX_STATUS, d);
    chk(d[0], 1'h1, "overflow flag");
    wr(IDX_STATUS, 8'h01);
    @(posedge aclk);
    gpio_out <= 2'h2;
    $display("test low duty done");
  endtask
  task automatic t_ext();
    int w, p;
    for (int c = 1; c < 4; c++) begin
      start(8'hF0, 8'hF4, 8'h03, c[7:0], 8'h71);
      lvl_wait(1'h1);
      meas(w, p);
      for (int k = 0; k < 4; k++) begin
        meas(w, p);
        chk(w, 4 + comp[c][k], "phase width");
      end
    end
    $display("test extension done");
  endtask
  task automatic t_one();
    logic [31:0] d;
    int rises, bad;
    logic prev;
    start(8'hF0, 8'hF4, 8'h01, 8'h03, 8'h73);
    for (int i = 0; i < 2; i++) begin
      if (i > 0)
        wr(IDX_CONTROL, 8'hF3);
      rises = 0;
      bad = 0;
      prev = 1'h0;
      repeat (60) begin
        @(negedge aclk);
        rises += int'(pin_level[0] === 1'h1 && prev === 1'h0);
        prev = pin_level[0];
        bad += int'(pin_out[1] !== gpio_out[1]);
      end
      chk(rises, 1, "single pulse");
      chk(bad, 0, "pin b stays gpio");
      rd(IDX_CONTROL, d);
      chk(d[0], 1'h0, "output enable cleared");
      chk({pin_oe[0], pin_out[0]}, {gpio_oe[0], gpio_out[0]}, "pin a back to gpio");
    end
    $display("test one pulse done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_cont();
    t_rate();
    t_low();
    t_ext();
    t_one();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
